// >>> core/fcb_defs.svh
// register indices, field positions, reset values of the coefficient bank
`ifndef FCB_DEFS_SVH
`define FCB_DEFS_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define FCB_IDX_TAP3 12'h41c
`define FCB_IDX_TAP4 12'h41e
`define FCB_IDX_CENTER 12'h420
`define FCB_IDX_TAP6 12'h423
`define FCB_IDX_TAP7 12'h425
`define FCB_IDX_FIRST 12'h41c
`define FCB_IDX_LAST 12'h426
`define FCB_IDX_CFG 12'h430
`define FCB_IDX_STATUS 12'h431

// ---------------------------------------------------------------
// widths and field positions
// ---------------------------------------------------------------
`define FCB_SIDE_REG_W 16
`define FCB_SIDE_COEFF_W 12
`define FCB_CENTER_REG_W 24
`define FCB_CENTER_COEFF_W 18
`define FCB_CFG_W 9
`define FCB_CFG_MODE_LSB 0
`define FCB_CFG_SCW_LSB 2
`define FCB_CFG_MERGE_BIT 5
`define FCB_CFG_SHARE_BIT 6
`define FCB_CFG_LINK_BIT 8
`define FCB_ST_ACTIVE_BIT 0
`define FCB_ST_MODE_RSV_BIT 1
`define FCB_ST_NO_MERGE_BIT 2
`define FCB_ST_SINGLE_BIT 3
`define FCB_ST_LATE_WR_BIT 8

// ---------------------------------------------------------------
// mode codes and reset values
// ---------------------------------------------------------------
`define FCB_MODE_OFF 2'h0
`define FCB_MODE_ON 2'h2
`define FCB_RST_SIDE 16'h0000
`define FCB_RST_CENTER 24'h000000
`define FCB_RST_CFG 9'h000

`endif

// >>> core/fcb_pkg.sv
// types shared by the coefficient bank modules
`include "fcb_defs.svh"

package fcb_pkg;

	// -----------------------------------------------------------
	// carriers
	// -----------------------------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [13:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} fcb_apb_req_t;

	typedef struct packed {
		logic signed [`FCB_SIDE_COEFF_W-1:0] tap3;
		logic signed [`FCB_SIDE_COEFF_W-1:0] tap4;
		logic signed [`FCB_CENTER_COEFF_W-1:0] center;
		logic signed [`FCB_SIDE_COEFF_W-1:0] tap6;
		logic signed [`FCB_SIDE_COEFF_W-1:0] tap7;
	} fcb_taps_t;

	typedef enum logic [1:0] {
		FCB_MODE_DISABLED = 2'b00,
		FCB_MODE_RSV1 = 2'b01,
		FCB_MODE_ENABLED = 2'b10,
		FCB_MODE_RSV3 = 2'b11
	} fcb_mode_t;

endpackage : fcb_pkg

// >>> core/fcb_coeff_reg.sv
// one coefficient register with byte-lane writes and masked readback
`timescale 1ns/1ps

module fcb_coeff_reg import fcb_pkg::*; #(
	parameter int REG_W = 16,
	parameter int COEFF_W = 12,
	parameter logic [REG_W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic wr_en,
	input wire logic [3:0] wstrb,
	input wire logic [31:0] wdata,
	output logic [REG_W-1:0] value,
	output logic [31:0] rdata
);

	// -----------------------------------------------------------
	// storage, one byte lane at a time
	// -----------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < REG_W / 8; b = b + 1) begin : g_lane
			always_ff @(posedge clk) begin
				if (srst) begin
					value[b*8 +: 8] <= RST_VAL[b*8 +: 8];
				end else if (wr_en && wstrb[b]) begin
					value[b*8 +: 8] <= wdata[b*8 +: 8];
				end
			end
		end
	endgenerate

	// -----------------------------------------------------------
	// readback
	// -----------------------------------------------------------
	logic [REG_W-1:0] msb_mask;
	assign msb_mask = ~(REG_W'(1) << COEFF_W - 1);

	assign rdata = {{(32 - REG_W){1'b0}}, value & msb_mask};

endmodule : fcb_coeff_reg

// >>> core/fcb_bank.sv
// channel A equaliser_fir coefficient bank, taps three to seven, on APB
`timescale 1ns/1ps

module fcb_bank import fcb_pkg::*; #(
	parameter int ADDR_W = 14
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic SINGLE_CHANNEL,
	input fcb_pkg::fcb_taps_t B_OWN_TAPS,
	output fcb_pkg::fcb_taps_t A_TAPS,
	output fcb_pkg::fcb_taps_t B_TAPS,
	output logic FILTER_EN,
	output logic MERGE_EN,
	output logic [2:0] SIDE_WEIGHT,
	output logic SERIAL_LINK_EN,
	output logic LATE_WRITE
);

	// -----------------------------------------------------------
	// decode helpers
	// -----------------------------------------------------------
	function automatic logic fcb_in_bank(input logic [11:0] idx);
		fcb_in_bank = (idx >= `FCB_IDX_FIRST) && (idx <= `FCB_IDX_LAST);
	endfunction : fcb_in_bank

	function automatic logic fcb_hit(input logic [11:0] idx,
			input logic [11:0] target, input logic aligned);
		fcb_hit = aligned && (idx == target);
	endfunction : fcb_hit

	// -----------------------------------------------------------
	// request carrier
	// -----------------------------------------------------------
	fcb_apb_req_t req;
	assign req = {PSEL, PENABLE, PWRITE, 14'(PADDR), PWDATA, PSTRB};

	wire logic [11:0] idx;
	wire logic aligned;
	wire logic setup;
	wire logic access;
	assign idx = req.paddr[13:2];
	assign aligned = (req.paddr[1:0] == 2'h0);
	assign setup = req.psel && !req.penable;
	assign access = req.psel && req.penable;

	// -----------------------------------------------------------
	// address decode
	// -----------------------------------------------------------
	wire logic hit_tap3;
	wire logic hit_tap4;
	wire logic hit_center;
	wire logic hit_tap6;
	wire logic hit_tap7;
	wire logic hit_cfg;
	wire logic hit_status;
	wire logic hit_bank;
	wire logic mapped;

	assign hit_tap3 = fcb_hit(idx, `FCB_IDX_TAP3, aligned);
	assign hit_tap4 = fcb_hit(idx, `FCB_IDX_TAP4, aligned);
	assign hit_center = fcb_hit(idx, `FCB_IDX_CENTER, aligned);
	assign hit_tap6 = fcb_hit(idx, `FCB_IDX_TAP6, aligned);
	assign hit_tap7 = fcb_hit(idx, `FCB_IDX_TAP7, aligned);
	assign hit_cfg = fcb_hit(idx, `FCB_IDX_CFG, aligned);
	assign hit_status = fcb_hit(idx, `FCB_IDX_STATUS, aligned);

	// tail indices of wide registers
	// tail indices read zero and drop writes, so a word walk never faults
	assign hit_bank = aligned && fcb_in_bank(idx);
	assign mapped = hit_bank || hit_cfg || hit_status;

	// -----------------------------------------------------------
	// write strobes
	// -----------------------------------------------------------
	// writes land only at the access edge, never in setup
	wire logic wr_acc = access && req.pwrite;
	wire logic wr_tap3 = wr_acc && hit_tap3;
	wire logic wr_tap4 = wr_acc && hit_tap4;
	wire logic wr_center = wr_acc && hit_center;
	wire logic wr_tap6 = wr_acc && hit_tap6;
	wire logic wr_tap7 = wr_acc && hit_tap7;
	wire logic wr_cfg = wr_acc && hit_cfg;
	wire logic wr_status = wr_acc && hit_status;
	wire logic wr_coeff = wr_tap3 || wr_tap4 || wr_center || wr_tap6 ||
		wr_tap7;

	// -----------------------------------------------------------
	// coefficient registers
	// -----------------------------------------------------------
	logic [`FCB_SIDE_REG_W-1:0] tap3_q;
	logic [`FCB_SIDE_REG_W-1:0] tap4_q;
	logic [`FCB_CENTER_REG_W-1:0] center_q;
	logic [`FCB_SIDE_REG_W-1:0] tap6_q;
	logic [`FCB_SIDE_REG_W-1:0] tap7_q;
	logic [31:0] rd_tap3;
	logic [31:0] rd_tap4;
	logic [31:0] rd_center;
	logic [31:0] rd_tap6;
	logic [31:0] rd_tap7;

	fcb_coeff_reg #(
		.REG_W(`FCB_SIDE_REG_W),
		.COEFF_W(`FCB_SIDE_COEFF_W),
		.RST_VAL(`FCB_RST_SIDE)
	) u_tap3 (
		.clk(CLK),
		.srst(SRST),
		.wr_en(wr_tap3),
		.wstrb(req.pstrb),
		.wdata(req.pwdata),
		.value(tap3_q),
		.rdata(rd_tap3)
	);

	fcb_coeff_reg #(
		.REG_W(`FCB_SIDE_REG_W),
		.COEFF_W(`FCB_SIDE_COEFF_W),
		.RST_VAL(`FCB_RST_SIDE)
	) u_tap4 (
		.clk(CLK),
		.srst(SRST),
		.wr_en(wr_tap4),
		.wstrb(req.pstrb),
		.wdata(req.pwdata),
		.value(tap4_q),
		.rdata(rd_tap4)
	);

	fcb_coeff_reg #(
		.REG_W(`FCB_CENTER_REG_W),
		.COEFF_W(`FCB_CENTER_COEFF_W),
		.RST_VAL(`FCB_RST_CENTER)
	) u_center (
		.clk(CLK),
		.srst(SRST),
		.wr_en(wr_center),
		.wstrb(req.pstrb),
		.wdata(req.pwdata),
		.value(center_q),
		.rdata(rd_center)
	);

	fcb_coeff_reg #(
		.REG_W(`FCB_SIDE_REG_W),
		.COEFF_W(`FCB_SIDE_COEFF_W),
		.RST_VAL(`FCB_RST_SIDE)
	) u_tap6 (
		.clk(CLK),
		.srst(SRST),
		.wr_en(wr_tap6),
		.wstrb(req.pstrb),
		.wdata(req.pwdata),
		.value(tap6_q),
		.rdata(rd_tap6)
	);

	fcb_coeff_reg #(
		.REG_W(`FCB_SIDE_REG_W),
		.COEFF_W(`FCB_SIDE_COEFF_W),
		.RST_VAL(`FCB_RST_SIDE)
	) u_tap7 (
		.clk(CLK),
		.srst(SRST),
		.wr_en(wr_tap7),
		.wstrb(req.pstrb),
		.wdata(req.pwdata),
		.value(tap7_q),
		.rdata(rd_tap7)
	);

	// -----------------------------------------------------------
	// configuration register
	// -----------------------------------------------------------
	logic [`FCB_CFG_W-1:0] cfg;
	logic [`FCB_CFG_W-1:0] next_cfg;

	always_comb begin
		next_cfg = cfg;
		if (wr_cfg && req.pstrb[0]) begin
			next_cfg[7:0] = req.pwdata[7:0];
		end
		if (wr_cfg && req.pstrb[1]) begin
			next_cfg[`FCB_CFG_LINK_BIT] = req.pwdata[`FCB_CFG_LINK_BIT];
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			cfg <= `FCB_RST_CFG;
		end else begin
			cfg <= next_cfg;
		end
	end

	fcb_mode_t mode;
	wire logic merge_bit;
	wire logic share_bit;
	wire logic link_bit;
	assign mode = fcb_mode_t'(cfg[`FCB_CFG_MODE_LSB +: 2]);
	assign merge_bit = cfg[`FCB_CFG_MERGE_BIT];
	assign share_bit = cfg[`FCB_CFG_SHARE_BIT];
	assign link_bit = cfg[`FCB_CFG_LINK_BIT];

	// -----------------------------------------------------------
	// filter control
	// -----------------------------------------------------------
	wire logic filter_on;
	wire logic mode_rsv;
	wire logic use_a_for_b;
	wire logic no_merge_warn;

	// only code 2 enables
	// reserved codes leave the filter off rather than guess a meaning
	assign filter_on = (mode == FCB_MODE_ENABLED);
	assign mode_rsv = (mode == FCB_MODE_RSV1) || (mode == FCB_MODE_RSV3);

	assign use_a_for_b = share_bit || merge_bit;

	assign no_merge_warn = SINGLE_CHANNEL && !merge_bit;

	// -----------------------------------------------------------
	// tap outputs
	// -----------------------------------------------------------
	fcb_taps_t a_taps;
	fcb_taps_t b_taps;

	// datapath sees the stored coefficient field, msb included; only readback loses the msb
	assign a_taps.tap3 = tap3_q[`FCB_SIDE_COEFF_W-1:0];
	assign a_taps.tap4 = tap4_q[`FCB_SIDE_COEFF_W-1:0];
	assign a_taps.center = center_q[`FCB_CENTER_COEFF_W-1:0];
	assign a_taps.tap6 = tap6_q[`FCB_SIDE_COEFF_W-1:0];
	assign a_taps.tap7 = tap7_q[`FCB_SIDE_COEFF_W-1:0];

	assign b_taps = use_a_for_b ? a_taps : B_OWN_TAPS;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			A_TAPS <= '0;
			B_TAPS <= '0;
			FILTER_EN <= 1'b0;
			MERGE_EN <= 1'b0;
			SIDE_WEIGHT <= 3'h0;
			SERIAL_LINK_EN <= 1'b0;
		end else begin
			A_TAPS <= a_taps;
			B_TAPS <= b_taps;
			FILTER_EN <= filter_on;
			MERGE_EN <= merge_bit;
			SIDE_WEIGHT <= cfg[`FCB_CFG_SCW_LSB +: 3];
			SERIAL_LINK_EN <= link_bit;
		end
	end

	// -----------------------------------------------------------
	// late write flag
	// -----------------------------------------------------------
	logic late_wr;
	wire logic late_set;
	wire logic late_clr;

	// flag coefficient writes while link runs
	// the write is still taken: blocking it would hide the host's mistake
	assign late_set = wr_coeff && link_bit;
	assign late_clr = wr_status && req.pstrb[1] &&
		req.pwdata[`FCB_ST_LATE_WR_BIT];

	always_ff @(posedge CLK) begin
		if (SRST) begin
			late_wr <= 1'b0;
		end else if (late_set) begin
			late_wr <= 1'b1;
		end else if (late_clr) begin
			late_wr <= 1'b0;
		end
	end

	assign LATE_WRITE = late_wr;

	// -----------------------------------------------------------
	// read mux and APB answer
	// -----------------------------------------------------------
	logic [31:0] status_word;
	logic [31:0] next_prdata;
	logic slverr;

	always_comb begin
		status_word = 32'h0;
		status_word[`FCB_ST_ACTIVE_BIT] = filter_on;
		status_word[`FCB_ST_MODE_RSV_BIT] = mode_rsv;
		status_word[`FCB_ST_NO_MERGE_BIT] = no_merge_warn;
		status_word[`FCB_ST_SINGLE_BIT] = SINGLE_CHANNEL;
		status_word[`FCB_ST_LATE_WR_BIT] = late_wr;
	end

	always_comb begin
		if (hit_tap3) begin
			next_prdata = rd_tap3;
		end else if (hit_tap4) begin
			next_prdata = rd_tap4;
		end else if (hit_center) begin
			next_prdata = rd_center;
		end else if (hit_tap6) begin
			next_prdata = rd_tap6;
		end else if (hit_tap7) begin
			next_prdata = rd_tap7;
		end else if (hit_cfg) begin
			next_prdata = {23'h0, cfg};
		end else if (hit_status) begin
			next_prdata = status_word;
		end else begin
			next_prdata = 32'h0;
		end
	end

	// caught at the setup edge: PRDATA is a flop and access never waits
	always_ff @(posedge CLK) begin
		if (SRST) begin
			PRDATA <= 32'h0;
			slverr <= 1'b0;
		end else if (setup) begin
			PRDATA <= req.pwrite ? 32'h0 : next_prdata;
			slverr <= !mapped;
		end
	end

	assign PREADY = 1'b1;
	assign PSLVERR = access && slverr;

endmodule : fcb_bank

// >>> verif/fcb_bank_monitor.sv
// concurrent checks on the coefficient bank ports
`timescale 1ns/1ps

module fcb_bank_monitor
	import fcb_pkg::*;
#(
	parameter int ADDR_W = 14
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic SINGLE_CHANNEL,
	input wire fcb_taps_t B_OWN_TAPS,
	input wire fcb_taps_t A_TAPS,
	input wire fcb_taps_t B_TAPS,
	input wire logic FILTER_EN,
	input wire logic MERGE_EN,
	input wire logic [2:0] SIDE_WEIGHT,
	input wire logic SERIAL_LINK_EN,
	input wire logic LATE_WRITE
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);

	// ---------------------------------------------------------------
	// decode of the watched access
	// ---------------------------------------------------------------
	wire logic acc;
	wire logic rd_acc;
	wire logic side_a;
	wire logic gap_a;
	wire logic cfg_wr;
	assign acc = PSEL && PENABLE;
	assign rd_acc = acc && !PWRITE;
	assign side_a = PADDR == 14'h1070 || PADDR == 14'h1078 ||
		PADDR == 14'h108c || PADDR == 14'h1094;
	assign gap_a = PADDR == 14'h1074 || PADDR == 14'h107c ||
		PADDR == 14'h1084 || PADDR == 14'h1088 || PADDR == 14'h1090;
	assign cfg_wr = acc && PWRITE && PADDR == 14'h10c0 && PSTRB[0];

	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	a_err_in_access: assert property (
		PSLVERR |-> acc) else $error("error outside access phase");
	a_err_misalign: assert property (
		acc && PADDR[1:0] != 2'h0 |-> PSLVERR) else $error("misaligned accepted");
	a_gap_reads_zero: assert property (
		rd_acc && gap_a |-> PRDATA == 32'h0 && !PSLVERR)
		else $error("tail index not zero");
	a_side_msb_hidden: assert property (
		rd_acc && side_a |-> PRDATA[31:16] == 16'h0 && !PRDATA[11])
		else $error("side readback msb shown");
	a_center_msb_hidden: assert property (
		rd_acc && PADDR == 14'h1080 |-> PRDATA[31:24] == 8'h0 && !PRDATA[17])
		else $error("center readback msb shown");
	a_mode_to_enable: assert property (
		cfg_wr |-> ##2 FILTER_EN == ($past(PWDATA[1:0], 2) == 2'h2))
		else $error("filter enable wrong");
	a_merge_follows: assert property (
		cfg_wr |-> ##2 MERGE_EN == $past(PWDATA[5], 2))
		else $error("merge enable wrong");
	a_merge_b_taps: assert property (
		MERGE_EN && $past(MERGE_EN) |-> B_TAPS == A_TAPS)
		else $error("merged b taps differ");
	a_late_flag: assert property (
		acc && PWRITE && (side_a || PADDR == 14'h1080) && SERIAL_LINK_EN
		|-> ##[1:2] LATE_WRITE) else $error("late write not flagged");
	a_reset_clears: assert property (disable iff (1'b0)
		SRST |=> A_TAPS == '0 && !LATE_WRITE && !SERIAL_LINK_EN)
		else $error("reset left state");
endmodule : fcb_bank_monitor

bind fcb_bank fcb_bank_monitor #(.ADDR_W(ADDR_W)) mon (.CLK(CLK),
	.SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .SINGLE_CHANNEL(SINGLE_CHANNEL),
	.B_OWN_TAPS(B_OWN_TAPS), .A_TAPS(A_TAPS), .B_TAPS(B_TAPS),
	.FILTER_EN(FILTER_EN), .MERGE_EN(MERGE_EN), .SIDE_WEIGHT(SIDE_WEIGHT),
	.SERIAL_LINK_EN(SERIAL_LINK_EN), .LATE_WRITE(LATE_WRITE));

// >>> verif/fcb_bank_tb.sv
// register-level testbench for the coefficient bank
`timescale 1ns/1ps

module fcb_bank_tb import fcb_pkg::*;;
	logic CLK = 0;
	logic SRST = 1;
	logic PSEL = 0;
	logic PENABLE = 0;
	logic PWRITE = 0;
	logic [13:0] PADDR = '0;
	logic [31:0] PWDATA = '0;
	logic [3:0] PSTRB = '0;
	logic SINGLE_CHANNEL = 0;
	fcb_taps_t B_OWN_TAPS = {12'h123, 12'h456, 18'h2789a, 12'hbcd, 12'hef0};
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	fcb_taps_t A_TAPS;
	fcb_taps_t B_TAPS;
	logic FILTER_EN;
	logic MERGE_EN;
	logic [2:0] SIDE_WEIGHT;
	logic SERIAL_LINK_EN;
	logic LATE_WRITE;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic er;
	logic [31:0] ex;
	logic [13:0] ta [5] = '{14'h1070, 14'h1078, 14'h1080, 14'h108c, 14'h1094};
	logic [31:0] pat [2] = '{32'hffffffff, 32'h00a55a5a};
	logic [65:0] a_exp;

	fcb_bank #(.ADDR_W(14)) uut (.CLK(CLK), .SRST(SRST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.SINGLE_CHANNEL(SINGLE_CHANNEL), .B_OWN_TAPS(B_OWN_TAPS),
		.A_TAPS(A_TAPS), .B_TAPS(B_TAPS), .FILTER_EN(FILTER_EN),
		.MERGE_EN(MERGE_EN), .SIDE_WEIGHT(SIDE_WEIGHT),
		.SERIAL_LINK_EN(SERIAL_LINK_EN), .LATE_WRITE(LATE_WRITE));

	always #12.5 CLK = ~CLK;

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task finish_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	task chk(input string nm, input logic [65:0] seen, input logic [65:0] ex);
		total_checks++;
		if (seen !== ex) begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", nm, ex, seen);
		end
	endtask : chk

	// request held until pready is seen high at a rising edge
	task apb(input logic wr, input logic [13:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge CLK);
		PSEL <= 1;
		PENABLE <= 0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		PSTRB <= s;
		@(posedge CLK);
		PENABLE <= 1;
		// only the bench timeout ends a wait for the answer
		do begin
			@(posedge CLK);
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
	endtask : apb

	task rchk(input string nm, input logic [13:0] a, input logic [31:0] ex);
		apb(0, a, 32'h0, 4'h0);
		chk(nm, {34'h0, rd}, {34'h0, ex});
		chk("no error", {65'h0, er}, 66'h0);
	endtask : rchk

	always @(posedge CLK) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			finish_test();
		end
	end

	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (20) @(posedge CLK);
		SRST <= 0;
		for (int i = 0; i < 5; i++) rchk("tap reset", ta[i], 32'h0);
		rchk("cfg reset", 14'h10c0, 32'h0);
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 5; i++) begin
				apb(1, ta[i], pat[p], 4'hf);
			end
			for (int i = 0; i < 5; i++) begin
				ex = pat[p] & (i == 2 ? 32'hfdffff : 32'hf7ff);
				rchk("tap rd", ta[i], ex);
			end
			a_exp = {12'ha5a, 12'ha5a, 18'h15a5a, 12'ha5a, 12'ha5a};
			if (p == 0) begin
				a_exp = {66{1'b1}};
			end
			chk("a taps", A_TAPS, a_exp);
			chk("b own", B_TAPS, B_OWN_TAPS);
		end
		apb(1, 14'h1070, 32'h0, 4'h1);
		rchk("byte lane", 14'h1070, 32'h5200);
		a_exp = {12'ha00, 12'ha5a, 18'h15a5a, 12'ha5a, 12'ha5a};
		rchk("tail", 14'h1084, 32'h0);
		apb(0, 14'h2000, 32'h0, 4'h0);
		chk("unmapped", {er, rd}, {1'b1, 32'h0});
		apb(0, 14'h1071, 32'h0, 4'h0);
		chk("misaligned", {65'h0, er}, 66'h1);
		for (int m = 0; m < 4; m++) begin
			apb(1, 14'h10c0, (m << 2) | m, 4'h1);
			repeat (2) @(posedge CLK);
			chk("filter en", FILTER_EN, m == 2);
			chk("side weight", SIDE_WEIGHT, m);
			rchk("mode status", 14'h10c4, {m[0], m == 2});
		end
		apb(1, 14'h10c0, 32'h40, 4'h1);
		repeat (2) @(posedge CLK);
		chk("share", B_TAPS, a_exp);
		apb(1, 14'h10c0, 32'h20, 4'h1);
		repeat (2) @(posedge CLK);
		chk("merge", {MERGE_EN, B_TAPS}, {1'b1, a_exp});
		SINGLE_CHANNEL <= 1;
		apb(1, 14'h10c0, 32'h0, 4'h1);
		repeat (2) @(posedge CLK);
		chk("b back", B_TAPS, B_OWN_TAPS);
		rchk("single", 14'h10c4, 32'hc);
		apb(1, 14'h10c0, 32'h100, 4'h2);
		apb(1, 14'h1078, 32'h0123, 4'h3);
		repeat (2) @(posedge CLK);
		chk("late", {SERIAL_LINK_EN, LATE_WRITE}, 66'h3);
		rchk("late tap", 14'h1078, 32'h0123);
		apb(1, 14'h10c0, 32'h0, 4'h2);
		apb(1, 14'h10c4, 32'h100, 4'h2);
		repeat (2) @(posedge CLK);
		chk("late clr", LATE_WRITE, 66'h0);
		SRST <= 1;
		repeat (2) @(posedge CLK);
		SRST <= 0;
		rchk("mid reset", 14'h1078, 32'h0);
		chk("a clear", A_TAPS, 66'h0);
		finish_test();
	end
endmodule : fcb_bank_tb
